//--- watchdog_status_indicator_bench.sv
/*
 bench of the status indicator: apb tasks and timed checks.
 assumes a ten-cycle tick divider for short runs.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module watchdog_status_indicator_bench;
   import wsi_pkg::*;
   localparam int DIV = 10;
   // codes of the pulsed inputs
   localparam int P_DONE   = 0;
   localparam int P_RETRIG = 1;
   localparam int P_GO     = 2;
   localparam int P_TRIP   = 3;
   localparam int P_PANEL  = 4;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, panel_reset = 1'b0, wd_trip = 1'b0;
   logic        wd_retrigger = 1'b0, self_check_done = 1'b0;
   logic        self_check_fault = 1'b0, temp_trip1 = 1'b0, temp_trip2 = 1'b0;
   logic        go = 1'b0, ext_trigger, pready, pslverr, wd_armed, top_led;
   logic        bottom_led, activity_trip_led, buzzer, irq, e;
   logic [7:0]  paddr = 8'h00;
   logic [15:0] wd_remaining_ms = 16'hFFFF;
   logic [31:0] pwdata = 32'h0, prdata, r;
   int          mismatches = 0, checked = 0, n;
   always #2.5 pclk = ~pclk;
   wsi_top #(.TICK_DIV_P(DIV)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .panel_reset(panel_reset), .wd_trip(wd_trip), .wd_retrigger(wd_retrigger),
      .ext_trigger(ext_trigger), .wd_remaining_ms(wd_remaining_ms),
      .self_check_done(self_check_done), .self_check_fault(self_check_fault),
      .temp_trip1(temp_trip1), .temp_trip2(temp_trip2), .wd_armed(wd_armed),
      .top_led(top_led), .bottom_led(bottom_led),
      .activity_trip_led(activity_trip_led), .buzzer(buzzer), .irq(irq));
   wsi_ext_src SRC (.pclk(pclk), .go(go), .ext_trigger(ext_trigger));
   task automatic summarize();
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      r = prdata;
      e = pslverr;
      if (k >= 20)
      begin
         mismatches++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // a used-up wait bound ends the run
   task automatic bound(input logic ok);
      if (ok !== 1'b1)
      begin
         mismatches++;
         summarize();
      end
   endtask
   // one-cycle high pulse on the chosen input
   task automatic pulse(input int which);
      case (which)
         P_DONE:   self_check_done <= 1'b1;
         P_RETRIG: wd_retrigger <= 1'b1;
         P_GO:     go <= 1'b1;
         P_TRIP:   wd_trip <= 1'b1;
         default:  panel_reset <= 1'b1;
      endcase
      @(posedge pclk);
      {self_check_done, wd_retrigger, go, wd_trip, panel_reset} <= 5'h00;
   endtask
   // measures one full half period of the top led
   task automatic half(input string nm, input int ms);
      logic v;
      int   k;
      for (int i = 0; i < 2; i++)
      begin
         v = top_led;
         k = 0;
         while (top_led === v && k < 40000) begin @(posedge pclk); k++; end
         bound(top_led !== v);
      end
      `CHK(nm, 1'b1, (k >= (ms - 2) * DIV) && (k <= (ms + 2) * DIV))
   endtask
   initial
   begin
      cyc(3);
      presetn <= 1'b1;
      cyc(3);
      `CHK("power-up beep", 1'b1, buzzer)
      apb(1'b0, POD_ADDR, 32'h0);
      `CHK("pod default", 32'd150, r)
      apb(1'b0, BEEP_ADDR, 32'h0);
      `CHK("beep default", {16'h0000, BEEP_RESET_VAL}, r)
      apb(1'b0, 8'h18, 32'h0);
      `CHK("unmapped err", 1'b1, e)
      half("pod toggle", 1000);
      pulse(P_DONE);
      cyc(2500);
      `CHK("health flash on", 1'b1, activity_trip_led)
      cyc(3500);
      `CHK("health flash off", 1'b0, activity_trip_led)
      pulse(P_RETRIG);
      cyc(20);
      `CHK("retrigger pulse", 1'b1, activity_trip_led)
      cyc(700);
      `CHK("retrigger end", 1'b0, activity_trip_led)
      pulse(P_GO);
      cyc(30);
      `CHK("ext trigger pulse", 1'b1, activity_trip_led)
      apb(1'b1, MASK_ADDR, 32'h1 << IRQ_TRIP);
      apb(1'b1, BEEP_ADDR, 32'd50);
      apb(1'b1, POD_ADDR, 32'd1);
      n = 0;
      while (wd_armed !== 1'b1 && n < 40000) begin @(posedge pclk); n++; end
      bound(wd_armed === 1'b1);
      `CHK("armed", 1'b1, wd_armed)
      apb(1'b0, STAT_ADDR, 32'h0);
      `CHK("state armed", WSI_ARMED, r[1:0])
      half("armed flash", 500);
      wd_remaining_ms <= 16'd4000;
      half("near flash", 100);
      wd_remaining_ms <= 16'hFFFF;
      apb(1'b1, POD_ADDR, 32'd5);
      pulse(P_TRIP);
      cyc(3);
      `CHK("trip latch", 1'b1, bottom_led)
      `CHK("trip irq", 1'b1, irq)
      `CHK("trip beep", 1'b1, buzzer)
      cyc(700);
      `CHK("beep length", 1'b0, buzzer)
      apb(1'b0, IRQS_ADDR, 32'h0);
      `CHK("irq status", 1'b1, r[IRQ_TRIP])
      apb(1'b1, IRQS_ADDR, 32'h1 << IRQ_TRIP);
      cyc(2);
      `CHK("irq cleared", 1'b0, irq)
      half("after trip", 1000);
      `CHK("latch held", 1'b1, bottom_led)
      apb(1'b1, CTRL_ADDR, 32'h1 << CTRL_TRIP_CLR);
      `CHK("sw clear", 1'b0, bottom_led)
      pulse(P_TRIP);
      cyc(3);
      pulse(P_PANEL);
      cyc(2);
      `CHK("panel clear", 1'b0, bottom_led)
      cyc(800);
      temp_trip2 <= 1'b1;
      cyc(100);
      `CHK("steady buzzer", 1'b1, buzzer)
      apb(1'b1, CTRL_ADDR, 32'h1 << CTRL_BUZ_DIS);
      cyc(2);
      `CHK("buzzer disabled", 1'b0, buzzer)
      temp_trip2 <= 1'b0;
      cyc(2);
      apb(1'b1, CTRL_ADDR, 32'h0);
      temp_trip1 <= 1'b1;
      n = 0;
      while (buzzer !== 1'b1 && n < 12000) begin @(posedge pclk); n++; end
      bound(buzzer === 1'b1);
      `CHK("temp beep on", 1'b1, buzzer)
      n = 0;
      while (buzzer === 1'b1 && n < 12000) begin @(posedge pclk); n++; end
      bound(buzzer === 1'b0);
      `CHK("temp beep off", 1'b0, buzzer)
      temp_trip1 <= 1'b0;
      self_check_fault <= 1'b1;
      pulse(P_DONE);
      cyc(500);
      `CHK("fault flash on", 1'b1, activity_trip_led)
      `CHK("fault beep on", 1'b1, buzzer)
      cyc(1000);
      `CHK("fault flash off", 1'b0, activity_trip_led)
      `CHK("fault beep held", 1'b1, buzzer)
      apb(1'b0, STAT_ADDR, 32'h0);
      `CHK("fault status", 1'b1, r[2])
      apb(1'b0, IRQS_ADDR, 32'h0);
      `CHK("temp irq", 1'b1, r[IRQ_TEMP])
      `CHK("fault irq", 1'b1, r[IRQ_FAULT])
      summarize();
   end
endmodule // watchdog_status_indicator_bench
`default_nettype wire

//--- wsi_ext_src.sv
/*
 external retrigger source: one clean rising edge per go pulse.
 assumes go is a one-cycle pulse driven from the pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module wsi_ext_src
#(
   parameter int HOLD = 500
)
(
   input  wire logic pclk,
   input  wire logic go,
   output logic      ext_trigger
);
   // each level held at least 2.5 us
   initial
   begin
      ext_trigger = 1'b0;
      forever
      begin
         @(posedge pclk);
         if (go)
         begin
            ext_trigger <= 1'b1;
            repeat (HOLD) @(posedge pclk);
            ext_trigger <= 1'b0;
            repeat (HOLD) @(posedge pclk);
         end
      end
   end
endmodule // wsi_ext_src
`default_nettype wire

//--- wsi_pkg.sv
/*
 package of the watchdog status indicator: register map, field positions,
 reset values and timing counts at a 200 MHz pclk.
 assumes nothing of its surroundings.
*/
`default_nettype none
package wsi_pkg;
   localparam int unsigned CLK_HZ           = 200_000_000;
   localparam int unsigned TICK_HZ          = 1000;
   localparam int unsigned TICK_DIV         = CLK_HZ / TICK_HZ;
   // times in milliseconds, counted in ticks; the power-on delay in seconds
   localparam int unsigned SLOW_MS          = 1000;
   localparam int unsigned ARMED_MS         = 500;
   localparam int unsigned NEAR_MS          = 100;
   localparam int unsigned ACT_PULSE_MS     = 50;
   localparam int unsigned HEALTH_MS        = 500;
   localparam int unsigned FAULT_MS         = 1000;
   localparam int unsigned FAULT_HALF_MS    = 100;
   localparam int unsigned BEEP_MS          = 200;
   localparam int unsigned BEEP_PERIOD_MS   = 1000;
   localparam int unsigned NEAR_WINDOW_MS   = 4000;
   localparam int unsigned POD_DEFAULT_S    = 150;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR  = 8'h00;
   localparam logic [7:0] POD_ADDR   = 8'h04;
   localparam logic [7:0] BEEP_ADDR  = 8'h08;
   localparam logic [7:0] STAT_ADDR  = 8'h0C;
   localparam logic [7:0] IRQS_ADDR  = 8'h10;
   localparam logic [7:0] MASK_ADDR  = 8'h14;
   // ctrl fields
   localparam int CTRL_BUZ_DIS  = 0;
   localparam int CTRL_TRIP_CLR = 1;
   // irq status fields
   localparam int IRQ_TRIP   = 0;
   localparam int IRQ_ARMED  = 1;
   localparam int IRQ_TEMP   = 2;
   localparam int IRQ_FAULT  = 3;
   localparam int IRQ_W      = 4;
   localparam logic [15:0] BEEP_RESET_VAL = 16'h00C8;
   typedef enum logic [1:0]
   {
      WSI_POD   = 2'b00,
      WSI_ARMED = 2'b01,
      WSI_NEAR  = 2'b10,
      WSI_TRIP  = 2'b11
   } wsi_state_type;
endpackage
`default_nettype wire

//--- wsi_tick.sv
/*
 free-running divider giving a one-cycle millisecond enable.
 assumes pclk at the package rate.
*/
`timescale 1ns/100ps
`default_nettype none
module wsi_tick
#(
   parameter int unsigned DIV = 200000
)
(
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   logic [31:0] cnt_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q <= 32'h0;
         tick  <= 1'b0;
      end
      else
      begin
         tick  <= (cnt_q == DIV - 1);
         cnt_q <= (cnt_q == DIV - 1) ? 32'h0 : cnt_q + 32'h1;
      end
   end
endmodule // wsi_tick
`default_nettype wire

//--- wsi_top.sv
/*
 watchdog status indicator: top LED, latched trip LED, activity LED and
 buzzer sequencing, with an APB register slave and an interrupt.
 assumes watchdog core inputs synchronous to pclk and pulses one cycle wide.
*/
//
// Contract
// - top led 1 s toggle during power-on delay
// - power-on delay default 150 s, programmable
// - armed: top led half-second flash
// - within 4 s of expiry: 0.1 s flash
// - after trip back to slow toggle
// - trip latches bottom led until cleared
// - retrigger gives short activity pulse
// - self-check: one 0.5 s flash or 1 s flashing
// - temp level1 beeps, level2 steady buzzer
// - brief beep at power-up and trip
// - fault adds one second beep
// - buzzer disable and reset beep length
`timescale 1ns/100ps
`default_nettype none
module wsi_top
   import wsi_pkg::*;
#(
   parameter int unsigned TICK_DIV_P = wsi_pkg::TICK_DIV
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        panel_reset,
   input  wire logic        wd_trip,
   input  wire logic        wd_retrigger,
   input  wire logic        ext_trigger,
   input  wire logic [15:0] wd_remaining_ms,
   input  wire logic        self_check_done,
   input  wire logic        self_check_fault,
   input  wire logic        temp_trip1,
   input  wire logic        temp_trip2,
   output logic             wd_armed,
   output logic             top_led,
   output logic             bottom_led,
   output logic             activity_trip_led,
   output logic             buzzer,
   output logic             irq
);
   import wsi_pkg::*;

   wsi_state_type state_q;
   logic          tick;
   logic [31:0]   ms_q;
   logic [15:0]   sec_q;
   logic [15:0]   pod_len_q;
   logic [15:0]   beep_len_q;
   logic          buz_dis_q;
   logic [IRQ_W-1:0] irqs_q;
   logic [IRQ_W-1:0] mask_q;
   logic          ext_q;
   logic [15:0]   act_q;
   logic [15:0]   chk_q;
   logic          chk_fault_q;
   logic [15:0]   beep_q;
   logic [15:0]   phase_q;
   logic          led_q;

   wsi_tick #(.DIV(TICK_DIV_P)) u_tick
   (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   function automatic logic [15:0] half_ms(input int unsigned ms);
      return 16'(ms);
   endfunction

   // apb decode
   wire wr_acc   = psel && penable && pwrite;
   wire rd_setup = psel && !penable && !pwrite;
   wire hit_ctrl = (paddr == CTRL_ADDR);
   wire hit_pod  = (paddr == POD_ADDR);
   wire hit_beep = (paddr == BEEP_ADDR);
   wire hit_stat = (paddr == STAT_ADDR);
   wire hit_irqs = (paddr == IRQS_ADDR);
   wire hit_mask = (paddr == MASK_ADDR);
   wire mapped   = hit_ctrl | hit_pod | hit_beep | hit_stat | hit_irqs | hit_mask;
   wire sw_trip_clr = wr_acc && hit_ctrl && pwdata[CTRL_TRIP_CLR];
   wire ext_rise = ext_trigger && !ext_q;
   wire retrig   = wd_retrigger || ext_rise;
   wire near_exp = (wd_remaining_ms <= 16'(NEAR_WINDOW_MS));
   // at or past the length, so a shortened delay still ends
   wire pod_done = tick && (sec_q >= pod_len_q);
   wire [15:0] half_len = (state_q == WSI_ARMED) ? half_ms(ARMED_MS)
                        : (state_q == WSI_NEAR)  ? half_ms(NEAR_MS)
                        : half_ms(SLOW_MS);
   wire [IRQ_W-1:0] irq_ev = {self_check_done && self_check_fault, temp_trip1,
                              pod_done && state_q == WSI_POD, wd_trip};
   wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, buz_dis_q}
      : hit_pod  ? {16'h0, pod_len_q}
      : hit_beep ? {16'h0, beep_len_q}
      : hit_stat ? {26'h0, temp_trip2, temp_trip1, bottom_led, chk_fault_q,
                    state_q}
      : hit_irqs ? {28'h0, irqs_q}
      : hit_mask ? {28'h0, mask_q}
      : 32'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata     <= 32'h0;
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         pod_len_q  <= 16'(POD_DEFAULT_S);
         beep_len_q <= BEEP_RESET_VAL;
         buz_dis_q  <= 1'b0;
         mask_q     <= '0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd_setup)
            prdata <= rd_mux;
         if (wr_acc && hit_ctrl)
            buz_dis_q <= pwdata[CTRL_BUZ_DIS];
         if (wr_acc && hit_pod)
            pod_len_q <= pwdata[15:0];
         if (wr_acc && hit_beep)
            beep_len_q <= pwdata[15:0];
         if (wr_acc && hit_mask)
            mask_q <= pwdata[IRQ_W-1:0];
      end
   end

   // sticky status: a set in the clear cycle wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irqs_q <= '0;
         irq    <= 1'b0;
      end
      else
      begin
         irqs_q <= (irqs_q & ~((wr_acc && hit_irqs) ? pwdata[IRQ_W-1:0] : '0)) | irq_ev;
         irq    <= |(irqs_q & mask_q);
      end
   end

   // watchdog state; timing from the single tick
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= WSI_POD;
         ms_q    <= 32'h0;
         sec_q   <= 16'h0;
      end
      else
      begin
         if (tick)
         begin
            ms_q <= (ms_q == 32'(SLOW_MS - 1)) ? 32'h0 : ms_q + 32'h1;
            if (state_q == WSI_POD && ms_q == 32'(SLOW_MS - 1))
               sec_q <= sec_q + 16'h1;
         end
         unique case (state_q)
            WSI_POD:
               if (pod_done)
                  state_q <= WSI_ARMED;
            WSI_ARMED, WSI_NEAR:
               if (wd_trip)
                  state_q <= WSI_TRIP;
               else
                  state_q <= near_exp ? WSI_NEAR : WSI_ARMED;
            WSI_TRIP:
            begin
               state_q <= WSI_POD;
               sec_q   <= 16'h0;
            end
         endcase
      end
   end

   // top led phase and latched trip led
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_q    <= 16'h0;
         led_q      <= 1'b0;
         top_led    <= 1'b0;
         bottom_led <= 1'b0;
         wd_armed   <= 1'b0;
      end
      else
      begin
         if (tick)
         begin
            if (phase_q + 16'h1 >= half_len)
            begin
               phase_q <= 16'h0;
               led_q   <= !led_q;
            end
            else
               phase_q <= phase_q + 16'h1;
         end
         top_led  <= led_q;
         wd_armed <= (state_q == WSI_ARMED) || (state_q == WSI_NEAR);
         if (wd_trip)
            bottom_led <= 1'b1;
         else if (panel_reset || sw_trip_clr)
            bottom_led <= 1'b0;
      end
   end

   // activity led: retrigger pulse and self-check report
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_q             <= 1'b0;
         act_q             <= 16'h0;
         chk_q             <= 16'h0;
         chk_fault_q       <= 1'b0;
         activity_trip_led <= 1'b0;
      end
      else
      begin
         ext_q <= ext_trigger;
         if (retrig)
            act_q <= half_ms(ACT_PULSE_MS);
         else if (tick && act_q != 16'h0)
            act_q <= act_q - 16'h1;
         if (self_check_done)
         begin
            chk_fault_q <= self_check_fault;
            chk_q <= self_check_fault ? half_ms(FAULT_MS) : half_ms(HEALTH_MS);
         end
         else if (tick && chk_q != 16'h0)
            chk_q <= chk_q - 16'h1;
         activity_trip_led <= (act_q != 16'h0)
            || (chk_q != 16'h0 && (!chk_fault_q
                || (chk_q / half_ms(FAULT_HALF_MS)) % 16'h2 == 16'h1));
      end
   end

   // buzzer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         beep_q <= half_ms(BEEP_MS);
         buzzer <= 1'b0;
      end
      else
      begin
         if (wd_trip)
            beep_q <= beep_len_q;
         else if (self_check_done && self_check_fault)
            beep_q <= half_ms(FAULT_MS);
         else if (tick && beep_q != 16'h0)
            beep_q <= beep_q - 16'h1;
         buzzer <= !buz_dis_q && (temp_trip2 || beep_q != 16'h0
                   || (temp_trip1 && ms_q < 32'(BEEP_MS)));
      end
   end

   trip_led_a : assert property (@(posedge pclk) disable iff (!presetn)
      wd_trip |=> bottom_led)
      else $error("trip led not latched");
   trip_return_a : assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == WSI_TRIP) |=> (state_q == WSI_POD))
      else $error("no return to delay");
   buz_dis_a : assert property (@(posedge pclk) disable iff (!presetn)
      buz_dis_q |=> !buzzer)
      else $error("buzzer sounds while disabled");
   buz_hot_a : assert property (@(posedge pclk) disable iff (!presetn)
      (temp_trip2 && !buz_dis_q) |=> buzzer)
      else $error("no steady buzzer");
   act_pulse_a : assert property (@(posedge pclk) disable iff (!presetn)
      wd_retrigger |=> ##1 activity_trip_led)
      else $error("no activity pulse");
   fault_beep_a : assert property (@(posedge pclk) disable iff (!presetn)
      (self_check_done && self_check_fault && !wd_trip) |=> beep_q == 16'(FAULT_MS))
      else $error("fault beep length wrong");
   trip_beep_a : assert property (@(posedge pclk) disable iff (!presetn)
      wd_trip |=> beep_q == $past(beep_len_q))
      else $error("reset beep length wrong");
   pod_arm_a : assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == WSI_POD && !pod_done) |=> !wd_armed [*1] ##0 state_q != WSI_NEAR)
      else $error("armed during delay");
   near_a : assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == WSI_ARMED && !wd_trip && near_exp) |=> state_q == WSI_NEAR)
      else $error("near state missed");
   tick_a : assert property (@(posedge pclk) disable iff (!presetn)
      tick |=> !tick)
      else $error("tick longer than a cycle");
   clr_a : assert property (@(posedge pclk) disable iff (!presetn)
      (sw_trip_clr && !wd_trip) |=> !bottom_led)
      else $error("trip led not cleared");
   half_a : assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == WSI_ARMED) |-> half_len == 16'(ARMED_MS))
      else $error("armed rate wrong");
   slow_a : assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == WSI_POD) |-> half_len == 16'(SLOW_MS))
      else $error("delay rate wrong");
   chk_a : assert property (@(posedge pclk) disable iff (!presetn)
      (self_check_done && !self_check_fault) |=> chk_q == 16'(HEALTH_MS))
      else $error("health flash length wrong");
endmodule // wsi_top
`default_nettype wire
